// ---- rtl/fps_params.svh ----
// constants of the program memory protection and security unit
//
// Contract
// [RQ1] refuse program and erase inside a top region on 512-byte boundary to 0xffff
// [RQ2] load working protection register from nonvolatile protection byte after reset
// [RQ3] working protection register takes writes only from background debug
// [RQ4] last unprotected address is select bits on top, ones below
// [RQ5] protection enabled only while protection-disable bit 0 is zero
// [RQ6] vector locations are protected whenever any protection is enabled
// [RQ7] redirection needs redirect-disable bit of option byte at 0xffbf zero
// [RQ8] redirection only when part, not all, of memory is protected
// [RQ9] redirect vector fetches 0xffc0 to 0xfffd, never the reset vector
// [RQ10] redirected fetch uses same low offset just below protected region
// [RQ11] while secure, unsecured or debug memory accesses: writes dropped, reads zero
// [RQ12] copy nonvolatile option byte into working option register at reset
// [RQ13] only security pattern 1:0 means unsecured
// [RQ14] on-chip debug module cannot be enabled while secure
// [RQ15] key-enable bit zero disables the backdoor key
// [RQ16] with key-access set, key location writes are comparison values
// [RQ17] software writes eight key bytes in order, never on adjacent cycles
// [RQ18] clearing key-access after eight matching bytes sets security to 1:0
// [RQ19] any mismatching key byte leaves security unchanged
// [RQ20] key writes count only from secure code, not from background debug
// [RQ21] passing blank check disengages security until reset
// [RQ22] secure debug program or page erase command codes flag access error
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

`define FPS_NONVOLATILE_PROTECTION_BYTE_ADDR   16'hffbd
`define FPS_NONVOLATILE_OPTION_BYTE_ADDR    16'hffbf
`define FPS_KEY_BASE      16'hffb0
`define FPS_VEC_LO        16'hffc0
`define FPS_VEC_HI        16'hfffd
`define FPS_FLASH_BASE    16'he000
`define FPS_PAGE_FILL     9'h1ff
`define FPS_PROT_DIS_BIT  0
`define FPS_NORED_BIT     6
`define FPS_KEY_ENABLE_BIT_BIT     7
`define FPS_SEC_UNSEC     2'b10
`define FPS_PROT_RESET    8'hff
`define FPS_OPT_RESET     8'hff
`define FPS_KEY_LEN       4'd8
`define FPS_CMD_BYTE_PROG 8'h20
`define FPS_CMD_BURST     8'h25
`define FPS_CMD_PAGE_ERA  8'h40

`endif

// ---- rtl/fps_pkg.sv ----
// types of the program memory protection and security unit
package fps_pkg;
	typedef enum logic [1:0] {
		FPS_LOAD = 2'b00,
		FPS_RUN  = 2'b01
	} fps_state_type;
endpackage

// ---- rtl/fps_unit.sv ----
// program memory block protection, vector redirection and security unit
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"

module fps_unit (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  nv_prot_i,
	input  wire logic [7:0]  nv_opt_i,
	input  wire logic [63:0] nv_key_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic [7:0]  bus_wdata_i,
	input  wire logic        bus_wr_i,
	input  wire logic        bus_rd_i,
	input  wire logic        bus_vec_fetch_i,
	input  wire logic        bus_mem_sel_i,
	input  wire logic        bus_src_bdm_i,
	input  wire logic        bus_src_secure_i,
	input  wire logic [7:0]  mem_rdata_i,
	input  wire logic        prot_wr_i,
	input  wire logic [7:0]  prot_wdata_i,
	input  wire logic        key_acc_wr_i,
	input  wire logic        key_acc_wdata_i,
	input  wire logic        cmd_wr_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic        pe_req_i,
	input  wire logic [15:0] pe_addr_i,
	input  wire logic        blank_done_i,
	input  wire logic        blank_ok_i,
	input  wire logic        dbg_en_req_i,
	output logic [15:0] mem_addr_o,
	output logic        mem_rd_o,
	output logic        mem_wr_o,
	output logic [7:0]  rd_data_o,
	output logic        pe_allow_o,
	output logic        pe_reject_o,
	output logic        access_err_o,
	output logic        dbg_enable_o,
	output logic        secure_o,
	output logic        prot_active_o,
	output logic        redirect_active_o,
	output logic        key_acc_o,
	output logic [7:0]  prot_o,
	output logic [7:0]  opt_o
);

	// ****************************************************************
	// state and working registers
	// ****************************************************************
	fps_pkg::fps_state_type state_reg;
	logic [7:0]  prot_reg;
	logic [7:0]  opt_reg;
	logic        key_acc_reg;
	logic [3:0]  key_cnt_reg;
	logic        key_ok_reg;
	logic        key_last_wr_reg;

	logic        run;
	logic        secure;
	logic        prot_en;
	logic [15:0] last_unprot;
	logic        all_prot;
	logic        redirect_en;
	logic        is_vector;
	logic        key_hit;
	logic        key_wr;
	logic        unlock_key;
	logic        unlock_blank;
	logic        blocked;
	logic [7:0]  key_byte;

	assign run = (state_reg == fps_pkg::FPS_RUN);

	// loads happen in the first cycle after release, never under reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= fps_pkg::FPS_LOAD;
		end else begin
			case (state_reg)
				fps_pkg::FPS_LOAD: state_reg <= fps_pkg::FPS_RUN;
				fps_pkg::FPS_RUN:  state_reg <= fps_pkg::FPS_RUN;
				default:           state_reg <= fps_pkg::FPS_LOAD;
			endcase
		end
	end

	// ****************************************************************
	// protection decode
	// ****************************************************************
	assign prot_en     = ~prot_reg[`FPS_PROT_DIS_BIT]; // RQ5
	assign last_unprot = {prot_reg[7:1], `FPS_PAGE_FILL}; // RQ4
	// region can reach below the array base with seven select bits; that case counts as all protected
	assign all_prot    = prot_en && (last_unprot < `FPS_FLASH_BASE);
	assign redirect_en = ~opt_reg[`FPS_NORED_BIT] && prot_en && !all_prot; // RQ7 RQ8
	assign is_vector   = (bus_addr_i >= `FPS_VEC_LO) && (bus_addr_i <= `FPS_VEC_HI); // RQ9

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prot_reg <= `FPS_PROT_RESET;
		end else if (!run) begin
			prot_reg <= nv_prot_i; // RQ2
		end else if (prot_wr_i && bus_src_bdm_i) begin
			prot_reg <= prot_wdata_i; // RQ3
		end
	end

	// ****************************************************************
	// security state
	// ****************************************************************
	assign secure       = (opt_reg[1:0] != `FPS_SEC_UNSEC); // RQ13
	assign unlock_blank = blank_done_i && blank_ok_i; // RQ21
	assign unlock_key   = key_acc_reg && key_acc_wr_i && !key_acc_wdata_i
		&& bus_src_secure_i && !bus_src_bdm_i
		&& opt_reg[`FPS_KEY_ENABLE_BIT_BIT] && key_ok_reg
		&& (key_cnt_reg == `FPS_KEY_LEN); // RQ15 RQ18 RQ19

	// only the security field changes after load; it sticks until reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			opt_reg <= `FPS_OPT_RESET;
		end else if (!run) begin
			opt_reg <= nv_opt_i; // RQ12
		end else if (unlock_key || unlock_blank) begin
			opt_reg[1:0] <= `FPS_SEC_UNSEC; // RQ18 RQ21
		end
	end

	// ****************************************************************
	// backdoor key comparison
	// ****************************************************************
	assign key_hit  = (bus_addr_i[15:3] == 13'(`FPS_KEY_BASE >> 3));
	assign key_wr   = run && bus_wr_i && key_hit && key_acc_reg
		&& bus_src_secure_i && !bus_src_bdm_i; // RQ16 RQ20
	assign key_byte = nv_key_i[{key_cnt_reg[2:0], 3'b000} +: 8];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			key_acc_reg <= 1'b0;
		end else if (run && key_acc_wr_i && !bus_src_bdm_i) begin
			key_acc_reg <= key_acc_wdata_i;
		end
	end

	// bytes are taken in arrival order; an out-of-place address or a
	// back-to-back write spoils the whole sequence
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			key_cnt_reg     <= 4'h0;
			key_ok_reg      <= 1'b1;
			key_last_wr_reg <= 1'b0;
		end else begin
			key_last_wr_reg <= key_wr;
			if (!key_acc_reg) begin
				key_cnt_reg <= 4'h0;
				key_ok_reg  <= 1'b1;
			end else if (key_wr) begin
				if (key_cnt_reg != `FPS_KEY_LEN) begin
					key_cnt_reg <= key_cnt_reg + 4'h1;
				end
				if ((bus_wdata_i != key_byte) || (bus_addr_i[2:0] != key_cnt_reg[2:0])
					|| key_last_wr_reg || (key_cnt_reg == `FPS_KEY_LEN)) begin
					key_ok_reg <= 1'b0; // RQ17 RQ19
				end
			end
		end
	end

	// ****************************************************************
	// memory access path
	// ****************************************************************
	assign blocked = secure && bus_mem_sel_i && (bus_src_bdm_i || !bus_src_secure_i); // RQ11

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_addr_o <= 16'h0000;
			mem_rd_o   <= 1'b0;
			mem_wr_o   <= 1'b0;
		end else begin
			mem_rd_o <= run && bus_rd_i && !blocked;
			mem_wr_o <= run && bus_wr_i && !blocked && !(key_hit && key_acc_reg); // RQ11 RQ16
			if (bus_vec_fetch_i && redirect_en && is_vector) begin
				mem_addr_o <= {last_unprot[15:6], bus_addr_i[5:0]}; // RQ9 RQ10
			end else begin
				mem_addr_o <= bus_addr_i;
			end
		end
	end

	// read data lags the strobe by one cycle; zero for blocked reads
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= (run && bus_rd_i && !blocked) ? mem_rdata_i : 8'h00; // RQ11
		end
	end

	// ****************************************************************
	// program and erase gating
	// ****************************************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pe_allow_o  <= 1'b0;
			pe_reject_o <= 1'b0;
		end else begin
			if (run && pe_req_i && prot_en
				&& ((pe_addr_i > last_unprot) || (pe_addr_i >= `FPS_VEC_LO))) begin
				pe_allow_o  <= 1'b0;
				pe_reject_o <= 1'b1; // RQ1 RQ6
			end else begin
				pe_allow_o  <= run && pe_req_i;
				pe_reject_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			access_err_o <= 1'b0;
		end else begin
			access_err_o <= run && cmd_wr_i && bus_src_bdm_i && secure
				&& ((cmd_code_i == `FPS_CMD_BYTE_PROG) || (cmd_code_i == `FPS_CMD_BURST)
				|| (cmd_code_i == `FPS_CMD_PAGE_ERA)); // RQ22
		end
	end

	// ****************************************************************
	// debug enable and status outputs
	// ****************************************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dbg_enable_o <= 1'b0;
		end else begin
			dbg_enable_o <= run && dbg_en_req_i && !secure; // RQ14
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			secure_o          <= 1'b1;
			prot_active_o     <= 1'b0;
			redirect_active_o <= 1'b0;
			key_acc_o         <= 1'b0;
			prot_o            <= `FPS_PROT_RESET;
			opt_o             <= `FPS_OPT_RESET;
		end else begin
			secure_o          <= secure;
			prot_active_o     <= run && prot_en;
			redirect_active_o <= run && redirect_en;
			key_acc_o         <= key_acc_reg;
			prot_o            <= prot_reg;
			opt_o             <= opt_reg;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_key_armed;
		key_acc_reg && opt_reg[`FPS_KEY_ENABLE_BIT_BIT] && key_ok_reg && (key_cnt_reg == `FPS_KEY_LEN);
	endsequence

	sequence s_key_close;
		key_acc_wr_i && !key_acc_wdata_i && bus_src_secure_i && !bus_src_bdm_i && run;
	endsequence

	AST_PE_REJECT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ1
		(run && pe_req_i && prot_en && pe_addr_i > last_unprot) |=> pe_reject_o && !pe_allow_o)
		else $error("write inside protected region allowed");

	AST_VEC_PROT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ6
		(run && pe_req_i && !prot_reg[0] && pe_addr_i >= 16'hffc0) |=> !pe_allow_o)
		else $error("vector location not protected");

	// armed once run has risen, so a release edge never compares against reset values
	AST_LOAD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ2
		$rose(run) |=> (prot_o == $past(nv_prot_i, 2)))
		else $error("protection byte not loaded");

	AST_PROT_APP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ3
		(run && !bus_src_bdm_i && $past(run)) |=> (prot_reg == $past(prot_reg)))
		else $error("application changed protection");

	AST_NO_PROT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ5
		(run && prot_reg[0]) |=> !prot_active_o && !pe_reject_o)
		else $error("protection active with disable bit set");

	AST_REDIR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ10
		(bus_vec_fetch_i && redirect_en && is_vector)
		|=> (mem_addr_o == {$past(prot_reg[7:1]), 3'b111, $past(bus_addr_i[5:0])}))
		else $error("redirected vector address wrong");

	AST_RESET_VEC: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ9
		(run && bus_addr_i >= 16'hfffe) |=> (mem_addr_o == $past(bus_addr_i)))
		else $error("reset vector redirected");

	AST_BLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ11
		(secure && bus_mem_sel_i && bus_src_bdm_i && (bus_rd_i || bus_wr_i))
		|=> !mem_wr_o && !mem_rd_o && (rd_data_o == 8'h00))
		else $error("secure memory reached from debug");

	AST_DBG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ14
		dbg_enable_o |-> !$past(secure))
		else $error("debug enabled while secure");

	AST_UNLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ18
		(s_key_armed and s_key_close) |=> (opt_reg[1:0] == 2'b10) ##1 !secure_o)
		else $error("matching key did not unlock");

	AST_NO_UNLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ19
		(run && secure && !key_ok_reg && !unlock_blank) |=> secure)
		else $error("bad key unlocked");

	AST_KEY_ENABLE_BIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ15
		(run && secure && !opt_reg[7] && !unlock_blank) |=> secure)
		else $error("key unlocked with key disabled");

	AST_BDM_KEY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ20
		(bus_src_bdm_i && key_acc_reg) |=> (key_cnt_reg == $past(key_cnt_reg)) || !key_acc_reg)
		else $error("debug key write counted");

	AST_BLANK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ21
		(run && unlock_blank) |=> !secure ##1 !secure_o)
		else $error("blank check did not unlock");

	AST_ACCERR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ22
		(run && secure && cmd_wr_i && bus_src_bdm_i && cmd_code_i == 8'h40) |=> access_err_o)
		else $error("secure debug page erase not flagged");

	AST_OPT_LOAD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ12
		$rose(run) |=> (opt_o == $past(nv_opt_i, 2)))
		else $error("option byte not loaded");

	AST_LAST_OPEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ4
		(run && pe_req_i && (pe_addr_i == {prot_reg[7:1], 9'h1ff}) && (pe_addr_i < 16'hffc0))
		|=> pe_allow_o && !pe_reject_o)
		else $error("last unprotected address refused");

	AST_KEY_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ16
		(run && bus_wr_i && key_acc_reg && (bus_addr_i[15:3] == 13'h1ff6)) |=> !mem_wr_o)
		else $error("key comparison write forwarded");

	AST_NO_REDIR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ7
		(run && opt_reg[6]) |=> !redirect_active_o)
		else $error("redirection with disable bit set");

endmodule

`default_nettype wire

// ---- verif/fps_mem_model.sv ----
// memory array and stored backdoor key model seen by the protection unit
`timescale 1ns/1ps
`default_nettype none
module fps_mem_model #(
	parameter logic [63:0] KEY = 64'h8877665544332211
) (
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_rd_i,
	output logic      [7:0]  mem_rdata_o,
	output logic      [63:0] nv_key_o
);
	// outside a read the array shows the inverse pattern, so stale data is never mistaken
	assign mem_rdata_o = bus_rd_i ? (bus_addr_i[7:0] ^ 8'h5a) : ~(bus_addr_i[7:0] ^ 8'h5a);
	assign nv_key_o    = KEY;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking testbench of the protection and security unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ****************************************
	// signals
	// ****************************************
	localparam logic [63:0] KEY = 64'h8877665544332211;
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	logic [7:0] nv_prot_i = 8'hff, nv_opt_i = 8'hff, bus_wdata_i = 8'h00, prot_wdata_i = 8'h00;
	logic [7:0] cmd_code_i = 8'h00, mem_rdata_i, rd_data_o, prot_o, opt_o;
	logic [15:0] bus_addr_i = 16'h0000, pe_addr_i = 16'h0000, mem_addr_o;
	logic [63:0] nv_key_i;
	logic bus_wr_i = 1'b0, bus_rd_i = 1'b0, bus_vec_fetch_i = 1'b0, bus_mem_sel_i = 1'b0;
	logic bus_src_bdm_i = 1'b0, bus_src_secure_i = 1'b0, prot_wr_i = 1'b0, key_acc_wr_i = 1'b0;
	logic key_acc_wdata_i = 1'b0, cmd_wr_i = 1'b0, pe_req_i = 1'b0, blank_done_i = 1'b0;
	logic blank_ok_i = 1'b0, dbg_en_req_i = 1'b0;
	logic mem_rd_o, mem_wr_o, pe_allow_o, pe_reject_o, access_err_o, dbg_enable_o, secure_o;
	logic prot_active_o, redirect_active_o, key_acc_o;
	int err_count = 0;
	int cmp_count = 0;

	fps_unit fps_unit_inst (.clk_i, .reset_n_i, .nv_prot_i, .nv_opt_i, .nv_key_i, .bus_addr_i,
		.bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_vec_fetch_i, .bus_mem_sel_i, .bus_src_bdm_i,
		.bus_src_secure_i, .mem_rdata_i, .prot_wr_i, .prot_wdata_i, .key_acc_wr_i,
		.key_acc_wdata_i, .cmd_wr_i, .cmd_code_i, .pe_req_i, .pe_addr_i, .blank_done_i,
		.blank_ok_i, .dbg_en_req_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .rd_data_o, .pe_allow_o,
		.pe_reject_o, .access_err_o, .dbg_enable_o, .secure_o, .prot_active_o,
		.redirect_active_o, .key_acc_o, .prot_o, .opt_o);
	fps_mem_model #(.KEY(KEY)) fps_mem_model_inst (.bus_addr_i(bus_addr_i),
		.bus_rd_i(bus_rd_i), .mem_rdata_o(mem_rdata_i), .nv_key_o(nv_key_i));

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask
	// strobes are one cycle wide; outputs are looked at just after the sampling edge
	task automatic tick;
		@(posedge clk_i);
		bus_wr_i <= 1'b0;
		bus_rd_i <= 1'b0;
		pe_req_i <= 1'b0;
		prot_wr_i <= 1'b0;
		key_acc_wr_i <= 1'b0;
		cmd_wr_i <= 1'b0;
		blank_done_i <= 1'b0;
		#1;
	endtask
	task automatic rst(input logic [7:0] p, input logic [7:0] o);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		nv_prot_i <= p;
		nv_opt_i <= o;
		repeat (2) @(posedge clk_i);
		#1;
		chk(16'(secure_o), 16'h0001, "secure in reset");
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk(16'(prot_o), 16'(p), "protection load");
		chk(16'(opt_o), 16'(o), "option load");
		chk(16'(secure_o), 16'(o[1:0] != 2'b10), "security decode");
	endtask
	task automatic pe(input logic [15:0] a, input logic rej);
		@(posedge clk_i);
		pe_req_i <= 1'b1;
		pe_addr_i <= a;
		tick;
		chk(16'(pe_reject_o), 16'(rej), "reject");
		chk(16'(pe_allow_o), 16'(!rej), "allow");
	endtask
	task automatic bus(input logic [15:0] a, input logic [7:0] d,
		input logic wr, input logic vec, input logic bdm, input logic sec);
		@(posedge clk_i);
		bus_addr_i <= a;
		bus_wdata_i <= d;
		bus_wr_i <= wr;
		bus_rd_i <= !wr;
		bus_vec_fetch_i <= vec;
		bus_mem_sel_i <= 1'b1;
		bus_src_bdm_i <= bdm;
		bus_src_secure_i <= sec;
		tick;
	endtask
	task automatic unlock(input logic [63:0] k, input logic bdm, input logic exp);
		@(posedge clk_i);
		key_acc_wr_i <= 1'b1;
		key_acc_wdata_i <= 1'b1;
		bus_src_bdm_i <= bdm;
		bus_src_secure_i <= !bdm;
		tick;
		tick;
		chk(16'(key_acc_o), 16'(!bdm), "key access bit");
		// arm from secure code, so debug key writes meet a set key-access bit
		@(posedge clk_i);
		key_acc_wr_i <= 1'b1;
		bus_src_bdm_i <= 1'b0;
		bus_src_secure_i <= 1'b1;
		tick;
		tick;
		chk(16'(key_acc_o), 16'h0001, "key access armed");
		// one idle cycle always separates the key writes
		for (int i = 0; i < 8; i++) begin
			bus(16'hffb0 + 16'(i), k[8*i +: 8], 1'b1, 1'b0, bdm, !bdm);
			chk(16'(mem_wr_o), 16'h0000, "key write forwarded");
		end
		@(posedge clk_i);
		key_acc_wr_i <= 1'b1;
		key_acc_wdata_i <= 1'b0;
		bus_src_bdm_i <= 1'b0;
		bus_src_secure_i <= 1'b1;
		tick;
		tick;
		chk(16'(secure_o), 16'(exp), "security after key");
		chk(16'(key_acc_o), 16'h0000, "key access cleared");
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_decode;
		for (int i = 0; i < 4; i++) begin
			rst(8'hff, 8'hfc | 8'(i));
		end
		$display("test decode done");
	endtask
	task automatic t_prot;
		rst(8'hf8, 8'hfe);
		chk(16'(prot_active_o), 16'h0001, "protection active");
		pe(16'hf9ff, 1'b0);
		pe(16'hfa00, 1'b1);
		pe(16'hffff, 1'b1);
		rst(8'hfe, 8'hfe);
		pe(16'hffbf, 1'b0);
		pe(16'hffc0, 1'b1);
		rst(8'hf9, 8'hfe);
		pe(16'hffc0, 1'b0);
		@(posedge clk_i);
		prot_wr_i <= 1'b1;
		prot_wdata_i <= 8'hf8;
		bus_src_bdm_i <= 1'b0;
		tick;
		tick;
		chk(16'(prot_o), 16'h00f9, "application write");
		@(posedge clk_i);
		prot_wr_i <= 1'b1;
		bus_src_bdm_i <= 1'b1;
		tick;
		tick;
		chk(16'(prot_o), 16'h00f8, "debug write");
		pe(16'hfa00, 1'b1);
		$display("test protection done");
	endtask
	task automatic t_redir;
		logic [7:0] tp [4] = '{8'hfc, 8'hfc, 8'hfd, 8'h00};
		logic [7:0] to [4] = '{8'h82, 8'hc2, 8'h82, 8'h82};
		logic [15:0] ea [4] = '{16'hfde0, 16'hffe0, 16'hffe0, 16'hffe0};
		for (int i = 0; i < 4; i++) begin
			rst(tp[i], to[i]);
			bus(16'hffe0, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
			chk(mem_addr_o, ea[i], "vector address");
			chk(16'(redirect_active_o), 16'(i == 0), "redirect active");
			chk(16'(rd_data_o), 16'h00ba, "vector data");
			bus(16'hfffe, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
			chk(mem_addr_o, 16'hfffe, "reset vector");
		end
		$display("test redirection done");
	endtask
	task automatic t_sec;
		rst(8'hff, 8'hff);
		bus(16'he100, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		chk(16'(mem_rd_o), 16'h0000, "debug read");
		chk(16'(rd_data_o), 16'h0000, "debug read data");
		bus(16'he100, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(16'(rd_data_o), 16'h0000, "unsecured read data");
		bus(16'he100, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		chk(16'(rd_data_o), 16'h005a, "secure read data");
		chk(16'(mem_rd_o), 16'h0001, "secure read");
		bus(16'he100, 8'h33, 1'b1, 1'b0, 1'b1, 1'b0);
		chk(16'(mem_wr_o), 16'h0000, "debug write");
		bus(16'he100, 8'h33, 1'b1, 1'b0, 1'b0, 1'b1);
		chk(16'(mem_wr_o), 16'h0001, "secure write");
		@(posedge clk_i);
		dbg_en_req_i <= 1'b1;
		tick;
		tick;
		chk(16'(dbg_enable_o), 16'h0000, "debug enable secure");
		rst(8'hff, 8'hfe);
		tick;
		chk(16'(dbg_enable_o), 16'h0001, "debug enable");
		bus(16'he100, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		chk(16'(rd_data_o), 16'h005a, "open debug read");
		@(posedge clk_i);
		dbg_en_req_i <= 1'b0;
		$display("test security done");
	endtask
	task automatic t_key;
		rst(8'hff, 8'h83);
		unlock(KEY, 1'b0, 1'b0);
		rst(8'hff, 8'h83);
		unlock(KEY ^ 64'h1, 1'b0, 1'b1);
		rst(8'hff, 8'h03);
		unlock(KEY, 1'b0, 1'b1);
		rst(8'hff, 8'h83);
		unlock(KEY, 1'b1, 1'b1);
		@(posedge clk_i);
		blank_done_i <= 1'b1;
		blank_ok_i <= 1'b0;
		tick;
		tick;
		chk(16'(secure_o), 16'h0001, "blank fail");
		@(posedge clk_i);
		blank_done_i <= 1'b1;
		blank_ok_i <= 1'b1;
		tick;
		tick;
		chk(16'(secure_o), 16'h0000, "blank pass");
		$display("test key and blank done");
	endtask
	task automatic t_cmd;
		logic [7:0] cc [6] = '{8'h20, 8'h25, 8'h40, 8'h41, 8'h05, 8'h20};
		logic ee [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		rst(8'hff, 8'hff);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			cmd_wr_i <= 1'b1;
			cmd_code_i <= cc[i];
			bus_src_bdm_i <= (i < 5);
			tick;
			chk(16'(access_err_o), 16'(ee[i]), "access error");
		end
		$display("test commands done");
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk_i);
		t_decode;
		t_prot;
		t_redir;
		t_sec;
		t_key;
		t_cmd;
		finish_test;
	end
	// a hang is cut short here and counted as a mismatch
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("mismatch %0t timeout", $time);
		finish_test;
	end
endmodule
`default_nettype wire
